// ### hw/code_fetch_pkg.sv
// constants, register map and types for the code fetch cache unit
`default_nettype none
package code_fetch_pkg;
	localparam logic [11:0] CTRL_OFFSET = 12'h010;
	localparam logic [11:0] EXTF_OFFSET = 12'h018;
	localparam logic [31:0] CTRL_RESET = 32'h0400_3f06;
	localparam logic [31:0] EXTF_RESET = 32'h0000_005f;
	// control bits that software may store; other bits read as zero
	localparam logic [31:0] CTRL_RW_MASK = 32'hf600_3f7f;
	localparam logic [31:0] EXTF_RW_MASK = 32'h0000_7fff;
	localparam int CACHE_DISABLE_BIT_POS = 0;
	localparam int CBP_POS = 1;
	localparam int ABORT_POS = 4;
	localparam int FLUSH_ALL_BIT_POS = 5;
	localparam int FLFB_POS = 6;
	localparam int GAP_LSB = 11;
	localparam int TEST_VIEW_POS = 27;
	localparam int TEST_HIT_POS = 25;
	localparam logic [3:0] SEG_CACHED = 4'ha;
	localparam logic [3:0] SEG_SCRATCH = 4'hc;
	localparam int LINES = 32;
	localparam int WORDS = 8;
	localparam int TAG_W = 26;
	localparam int SP_WORDS = 8192;
	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_FILL = 2'b01,
		FS_GAP = 2'b10,
		FS_FLUSH = 2'b11
	} fill_state_t;
endpackage
`default_nettype wire

// ### hw/code_fetch_cache_unit.sv
// code fetch unit: scratch-pad, direct-mapped cache, fill buffer, apb
//
// Design decision made here: the APB register port.
`default_nettype none
//////////////////////////////////////////////////////////////////////////
// Functional notes
// RQ1: bus reads of scratch-pad are 32-bit words
// RQ2: misaligned scratch-pad bus access returns error
// RQ3: bus writes word-aligned, supervisor only
// RQ4: scratch-pad fetch one cycle, 64 bits, read-only
// RQ5: 1 KB direct-mapped, 32 lines, 26-bit tag
// RQ6: eight words per line, per-word valid
// RQ7: segment 10 to buffer, cache if enabled
// RQ8: hit returns instruction, miss starts refill
// RQ9: disable and bypass combinations, both flush
// RQ10: bypass bit resets to one
// RQ11: 256-bit fill buffer, per-word valid
// RQ12: refill critical word to line end
// RQ13: refill start clears line valid bits
// RQ14: refill touches one line, no prefetch
// RQ15: flush-all bit clears cache and buffer
// RQ16: buffer flush bit clears buffer only
// RQ17: hold external bus port during burst
// RQ18: burst timing fields stored for bus unit
// RQ19: abort bit lets new miss abort fill
// RQ20: gap field inserts wait between bursts
// RQ21: test view bit reads zero
// RQ22: spare bits store written value
// RQ23: hold same-line hit during refill
//////////////////////////////////////////////////////////////////////////
module code_fetch_cache_unit
	import code_fetch_pkg::*;
(
	input wire logic mclk_in,
	input wire logic arst_n_in,
	// apb
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [15:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [2:0] pprot_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// core fetch
	input wire logic fetch_req_in,
	input wire logic [31:0] fetch_addr_in,
	output logic fetch_valid_out,
	output logic [63:0] fetch_data_out,
	// external burst fetch
	output logic ext_req_out,
	output logic [31:0] ext_addr_out,
	input wire logic ext_data_valid_in,
	input wire logic [31:0] ext_data_in,
	output logic ext_port_hold_out,
	output logic [14:0] ext_timing_out
);
	logic [31:0] ctrl_r, ctrl_nxt, extf_r, extf_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] scratch_pad_code_ram [SP_WORDS];
	logic [31:0] cdata [LINES][WORDS];
	logic [TAG_W-1:0] ctag [LINES];
	logic [WORDS-1:0] cval_r [LINES];
	logic [31:0] fb_data [WORDS];
	logic [WORDS-1:0] fb_val_r, fb_val_nxt;
	logic [26:0] fb_tag_r, fb_tag_nxt;
	fill_state_t st_r, st_nxt;
	logic [2:0] word_r, word_nxt, gap_r, gap_nxt;
	logic [4:0] line_r, line_nxt;
	logic [31:0] fa_r, fa_nxt;
	logic fv_r, fv_nxt;
	logic [63:0] fd_r, fd_nxt;
	logic sp_wr, fill_wr, flush_line_all, clr_line;
	logic cache_on, is_sp, is_cached, chit, fbhit, same_line_busy;
	logic [4:0] fl;
	logic [2:0] fw;
	logic [TAG_W-1:0] ft;
	logic [31:0] sp_rd;

	assign fl = fetch_addr_in[9:5];
	assign fw = fetch_addr_in[4:2];
	assign ft = fetch_addr_in[31:6];
	assign is_sp = fetch_addr_in[31:28] == SEG_SCRATCH
		&& fetch_addr_in[27:15] == 13'h0000;
	assign is_cached = fetch_addr_in[31:28] == SEG_CACHED; // RQ7
	assign cache_on = !ctrl_r[CACHE_DISABLE_BIT_POS] && !ctrl_r[CBP_POS]; // RQ9 RQ10
	assign same_line_busy = st_r == FS_FILL && line_r == fl; // RQ23
	assign chit = cache_on && !same_line_busy && ctag[fl] == ft
		&& cval_r[fl][fw]; // RQ5 RQ6
	assign fbhit = fb_tag_r == fetch_addr_in[31:5] && fb_val_r[fw]; // RQ11
	assign sp_rd = scratch_pad_code_ram[paddr_in[14:2]];

	//////////////////////////////////////////////////////////////////////
	// apb slave; scratch-pad window at 0x8000, registers below
	logic sp_sel, bad_align;
	assign sp_sel = paddr_in[15];
	// word-only access; half-open strobes count as misalignment
	assign bad_align = paddr_in[1:0] != 2'b00
		|| (pwrite_in && pstrb_in != 4'hf); // RQ1 RQ2 RQ3
	assign sp_wr = psel_in && penable_in && !pready_r && pwrite_in
		&& sp_sel && !bad_align && pprot_in[0]; // RQ3
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		extf_nxt = extf_r;
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		if (psel_in && penable_in && !pready_r)
		begin
			pready_nxt = 1'b1;
			prdata_nxt = 32'h0000_0000;
			if (sp_sel)
			begin
				pslverr_nxt = bad_align || (pwrite_in && !pprot_in[0]);
				if (!pwrite_in && !bad_align)
					prdata_nxt = sp_rd;
			end
			else if (paddr_in[11:0] == CTRL_OFFSET)
			begin
				if (pwrite_in)
					ctrl_nxt = pwdata_in & CTRL_RW_MASK; // RQ22
				else
					prdata_nxt = ctrl_r & ~(32'h0000_0001 << TEST_VIEW_POS); // RQ21
			end
			else if (paddr_in[11:0] == EXTF_OFFSET)
			begin
				if (pwrite_in)
					extf_nxt = pwdata_in & EXTF_RW_MASK; // RQ18
				else
					prdata_nxt = extf_r;
			end
			else
				pslverr_nxt = 1'b1;
		end
		// hardware ends a flush after one pass; set by write wins that cycle
		if (st_r == FS_FLUSH && !(pready_nxt && pwrite_in && !sp_sel))
		begin
			ctrl_nxt[FLUSH_ALL_BIT_POS] = 1'b0; // RQ15
			ctrl_nxt[FLFB_POS] = 1'b0; // RQ16
		end
	end
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctrl_r <= CTRL_RESET; // RQ10 RQ22
			extf_r <= EXTF_RESET;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			extf_r <= extf_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end
	always_ff @(posedge mclk_in)
	begin
		if (sp_wr)
			scratch_pad_code_ram[paddr_in[14:2]] <= pwdata_in;
	end

	//////////////////////////////////////////////////////////////////////
	// fetch service and refill sequencer
	logic miss, do_flush;
	assign miss = fetch_req_in && is_cached && !fbhit && !chit; // RQ8
	assign do_flush = ctrl_r[FLUSH_ALL_BIT_POS] || ctrl_r[FLFB_POS];
	assign flush_line_all = (st_r == FS_FLUSH && ctrl_r[FLUSH_ALL_BIT_POS])
		|| (ctrl_r[CACHE_DISABLE_BIT_POS] && ctrl_r[CBP_POS]); // RQ9 RQ15
	assign clr_line = st_nxt == FS_FILL && st_r != FS_FILL; // RQ13
	assign fill_wr = st_r == FS_FILL && ext_data_valid_in;
	always_comb
	begin
		st_nxt = st_r;
		word_nxt = word_r;
		line_nxt = line_r;
		fa_nxt = fa_r;
		gap_nxt = gap_r;
		fb_val_nxt = fb_val_r;
		fb_tag_nxt = fb_tag_r;
		fv_nxt = 1'b0;
		fd_nxt = fd_r;
		if (fetch_req_in && is_sp)
		begin
			fv_nxt = 1'b1; // RQ4
			fd_nxt = {scratch_pad_code_ram[{fetch_addr_in[14:3], 1'b1}],
				scratch_pad_code_ram[{fetch_addr_in[14:3], 1'b0}]};
		end
		else if (fetch_req_in && is_cached && fbhit)
		begin
			fv_nxt = 1'b1;
			fd_nxt = {32'h0000_0000, fb_data[fw]};
		end
		else if (fetch_req_in && is_cached && chit)
		begin
			fv_nxt = 1'b1; // RQ8
			fd_nxt = {32'h0000_0000, cdata[fl][fw]};
		end
		case (st_r)
			FS_IDLE:
			begin
				if (do_flush)
					st_nxt = FS_FLUSH;
				else if (miss)
				begin
					st_nxt = FS_FILL; // RQ12
					word_nxt = fw;
					line_nxt = fl;
					fa_nxt = {fetch_addr_in[31:2], 2'b00};
					fb_tag_nxt = fetch_addr_in[31:5];
					fb_val_nxt = '0;
				end
			end
			FS_FILL:
			begin
				if (miss && ctrl_r[ABORT_POS]
					&& fetch_addr_in[31:5] != fb_tag_r)
				begin
					st_nxt = FS_GAP; // RQ19
					gap_nxt = ctrl_r[GAP_LSB +: 3];
				end
				else if (ext_data_valid_in)
				begin
					fb_val_nxt[word_r] = 1'b1;
					fa_nxt = fa_r + 32'h0000_0004;
					word_nxt = word_r + 3'd1;
					// stop at line end, never into the next line
					if (word_r == 3'd7)
					begin
						st_nxt = FS_GAP; // RQ14
						gap_nxt = ctrl_r[GAP_LSB +: 3]; // RQ20
					end
				end
			end
			FS_GAP:
			begin
				if (gap_r == 3'd0)
					st_nxt = FS_IDLE;
				else
					gap_nxt = gap_r - 3'd1; // RQ20
			end
			FS_FLUSH:
			begin
				fb_val_nxt = '0; // RQ15 RQ16
				st_nxt = FS_IDLE;
			end
			default: st_nxt = FS_IDLE;
		endcase
	end
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st_r <= FS_IDLE;
			word_r <= 3'd0;
			line_r <= 5'd0;
			fa_r <= 32'h0000_0000;
			gap_r <= 3'd0;
			fb_val_r <= '0;
			fb_tag_r <= '0;
			fv_r <= 1'b0;
			fd_r <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			st_r <= st_nxt;
			word_r <= word_nxt;
			line_r <= line_nxt;
			fa_r <= fa_nxt;
			gap_r <= gap_nxt;
			fb_val_r <= fb_val_nxt;
			fb_tag_r <= fb_tag_nxt;
			fv_r <= fv_nxt;
			fd_r <= fd_nxt;
		end
	end
	always_ff @(posedge mclk_in)
	begin
		if (fill_wr)
			fb_data[word_r] <= ext_data_in; // RQ11
	end

	// per-line valid and data arrays
	genvar gi;
	for (gi = 0; gi < LINES; gi++)
	begin : g_line
		always_ff @(posedge mclk_in or negedge arst_n_in)
		begin
			if (!arst_n_in)
				cval_r[gi] <= '0;
			else if (flush_line_all)
				cval_r[gi] <= '0;
			else if (clr_line && line_nxt == gi)
				cval_r[gi] <= '0; // RQ13
			else if (fill_wr && line_r == gi)
				cval_r[gi][word_r] <= 1'b1; // RQ6
		end
		always_ff @(posedge mclk_in)
		begin
			if (clr_line && line_nxt == gi)
				ctag[gi] <= fa_nxt[31:6];
			if (fill_wr && line_r == gi)
				cdata[gi][word_r] <= ext_data_in; // RQ12
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs
	logic hold_r;
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			hold_r <= 1'b0;
		else
			hold_r <= st_nxt == FS_FILL; // RQ17
	end
	assign ext_port_hold_out = hold_r;
	assign ext_req_out = hold_r;
	assign ext_addr_out = fa_r;
	assign ext_timing_out = extf_r[14:0]; // RQ18
	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;
	assign fetch_valid_out = fv_r;
	assign fetch_data_out = fd_r;

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	chk_sp_one_cycle: assert property (fetch_req_in && is_sp // RQ4
		|=> fetch_valid_out) else $error("scratch fetch late");
	chk_misalign_err: assert property (psel_in && penable_in // RQ2
		&& !pready_r && sp_sel && paddr_in[1:0] != 2'b00
		|=> pready_out && pslverr_out) else $error("no error");
	chk_user_write: assert property (psel_in && penable_in // RQ3
		&& !pready_r && pwrite_in && sp_sel && !pprot_in[0]
		|=> pready_out && pslverr_out) else $error("user write taken");
	chk_test_read: assert property (pready_out && !pslverr_out // RQ21
		&& $past(!pwrite_in && paddr_in == 16'h0010)
		|-> !prdata_out[TEST_VIEW_POS]) else $error("test bit");
	chk_flush_end: assert property (st_r == FS_FLUSH // RQ16
		|=> fb_val_r == '0) else $error("buffer not flushed");
	chk_clear_line: assert property (clr_line // RQ13
		|=> cval_r[line_r] == '0) else $error("line kept");
	chk_no_wrap: assert property (st_r == FS_FILL && fill_wr // RQ12
		&& word_r == 3'd7 |=> st_r != FS_FILL) else $error("wrap");
	chk_hold_fill: assert property (st_r == FS_FILL // RQ17
		|-> ext_port_hold_out) else $error("port free");
	chk_gap_wait: assert property (st_r == FS_FILL // RQ20
		&& st_nxt == FS_GAP && ctrl_r[13:11] == 3'd7
		|=> st_r == FS_GAP [*8]) else $error("gap short");
	chk_bypass_miss: assert property (ctrl_r[CBP_POS] |-> !chit) // RQ9
		else $error("bypass hit");
	chk_abort_fill: assert property (st_r == FS_FILL && miss // RQ19
		&& ctrl_r[ABORT_POS] && fetch_addr_in[31:5] != fb_tag_r
		|=> st_r == FS_GAP) else $error("fill not aborted");
	chk_line_hold: assert property (fetch_req_in && is_cached // RQ23
		&& same_line_busy && !fbhit
		|=> !fetch_valid_out) else $error("stale line served");
	cov_fill: cover property (st_r == FS_IDLE ##1 st_r == FS_FILL);
	cov_hit: cover property (fetch_req_in && chit);
	cov_abort: cover property (st_r == FS_FILL ##1 st_r == FS_GAP
		&& !$past(fill_wr));
	cov_flush: cover property (st_r == FS_FLUSH);
	cov_gap: cover property (st_r == FS_GAP && gap_r == 3'd7);
endmodule // code_fetch_cache_unit
`default_nettype wire

// ### sim/ext_burst_mem_model.sv
// far-side model: external burst code memory feeding refill words
`default_nettype none
module ext_burst_mem_model #(
	parameter int LAT = 2
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic ext_req_in,
	input wire logic [31:0] ext_addr_in,
	output logic ext_data_valid_out,
	output logic [31:0] ext_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	always @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cnt <= 0;
			ext_data_valid_out <= 1'b0;
			ext_data_out <= 32'h0000_0000;
		end
		else if (ext_req_in && !ext_data_valid_out && cnt >= LAT)
		begin
			cnt <= 0;
			ext_data_valid_out <= 1'b1;
			ext_data_out <= ext_addr_in ^ 32'h5a5a_0000;
		end
		else
		begin
			cnt <= ext_req_in ? cnt + 1 : 0;
			ext_data_valid_out <= 1'b0;
			// bus not driven: toggle so stale data never looks valid
			ext_data_out <= ~ext_data_out;
		end
	end
endmodule // ext_burst_mem_model
`default_nettype wire

// ### sim/code_fetch_cache_unit_tb.sv
// testbench: apb registers, scratch-pad, cache refill and flush
`default_nettype none
module code_fetch_cache_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, faddr = 0, ext_addr, ext_d, r;
	logic [3:0] pstrb = 0;
	logic [2:0] pprot = 0;
	logic pready, pslverr, freq = 0, fvalid, ext_req, ext_dv, ext_hold, e, v;
	logic [63:0] fdata, d;
	logic [14:0] ext_tm;
	int failures = 0, n_checks = 0, nwords = 0;
	always #2 clk = ~clk;
	always @(posedge clk) if (ext_dv === 1'b1) nwords++;
	code_fetch_cache_unit code_fetch_cache_unit_i (.mclk_in(clk),
		.arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.pstrb_in(pstrb), .pprot_in(pprot), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .fetch_req_in(freq),
		.fetch_addr_in(faddr), .fetch_valid_out(fvalid),
		.fetch_data_out(fdata), .ext_req_out(ext_req),
		.ext_addr_out(ext_addr), .ext_data_valid_in(ext_dv),
		.ext_data_in(ext_d), .ext_port_hold_out(ext_hold),
		.ext_timing_out(ext_tm));
	ext_burst_mem_model ext_burst_mem_model_i (.mclk_in(clk),
		.arst_n_in(arst_n), .ext_req_in(ext_req), .ext_addr_in(ext_addr),
		.ext_data_valid_out(ext_dv), .ext_data_out(ext_d));
	//////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] wd, input logic [3:0] s, input logic [2:0] p);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		pstrb <= s;
		pprot <= p;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) failures++;
		// one idle edge so the next setup never re-drives psel this step
		@(posedge clk);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, 4'hf, 3'h1);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, 4'h0, 3'h1);
		chk({e, r}, {1'b0, exp});
	endtask
	task automatic fetch(input logic [31:0] a);
		freq <= 1'b1;
		faddr <= a;
		@(posedge clk);
		freq <= 1'b0;
		@(posedge clk);
		v = fvalid;
		d = fdata;
	endtask
	// a hit returns the model's word, a miss must stay silent
	task automatic fchk(input logic [31:0] a, input logic hit);
		fetch(a);
		chk({v, hit ? d[31:0] : 32'h0}, {hit, hit ? a ^ 32'h5a5a_0000 : 32'h0});
	endtask
	// waits out the refill plus the widest gap between bursts
	task automatic drain();
		int n;
		n = 0;
		while (ext_req !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		repeat (12) @(posedge clk);
		if (n == 200) failures++;
	endtask
	// keeps a missing fetch waiting from the end of one refill to the next
	task automatic gap_chk(input logic [31:0] a, input int min_gap);
		int n;
		n = 0;
		while (ext_req !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		freq <= 1'b1;
		faddr <= a;
		n = 0;
		while (ext_req !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		freq <= 1'b0;
		if (n == 200) failures++;
		chk(n >= min_gap, 1'b1);
	endtask
	//////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(16'h0010, 32'h0400_3f06);
		rd(16'h0018, 32'h0000_005f);
		wr(16'h0018, 32'hffff_ffff);
		rd(16'h0018, 32'h0000_7fff);
		chk(ext_tm, 15'h7fff);
		wr(16'h0010, 32'h0800_0408);
		rd(16'h0010, 32'h0000_0408);
		wr(16'h0010, 32'h0000_0008);
		apb(1'b0, 16'h0020, 0, 4'h0, 3'h1);
		chk(e, 1'b1);
		apb(1'b0, 16'h8002, 0, 4'h0, 3'h1);
		chk(e, 1'b1);
		apb(1'b1, 16'h8000, 32'h0000_0001, 4'hf, 3'h0);
		chk(e, 1'b1);
		apb(1'b1, 16'h8004, 32'h0000_0001, 4'h3, 3'h1);
		chk(e, 1'b1);
		wr(16'h8008, 32'h1111_2222);
		wr(16'h800c, 32'h3333_4444);
		apb(1'b0, 16'h800c, 0, 4'h0, 3'h0);
		chk({e, r}, {1'b0, 32'h3333_4444});
		fetch(32'hc000_0008);
		chk({v, d}, {1'b1, 64'h3333_4444_1111_2222});
		nwords = 0;
		fchk(32'ha000_0110, 1'b0);
		chk(ext_hold, 1'b1);
		drain();
		chk(nwords, 4);
		fchk(32'ha000_0110, 1'b1);
		fchk(32'ha000_011c, 1'b1);
		nwords = 0;
		fchk(32'ha000_0104, 1'b0);
		drain();
		chk(nwords, 7);
		fchk(32'ha000_0120, 1'b0);
		drain();
		wr(16'h0010, 32'h0000_0028);
		rd(16'h0010, 32'h0000_0008);
		fchk(32'ha000_0104, 1'b0);
		drain();
		wr(16'h0010, 32'h0000_004a);
		rd(16'h0010, 32'h0000_000a);
		fchk(32'ha000_0104, 1'b0);
		drain();
		wr(16'h0010, 32'h0000_0048);
		fchk(32'ha000_0104, 1'b1);
		wr(16'h0010, 32'h0000_0003);
		wr(16'h0010, 32'h0000_0048);
		fchk(32'ha000_0104, 1'b0);
		drain();
		wr(16'h0010, 32'h0000_0018);
		nwords = 0;
		fchk(32'ha000_0140, 1'b0);
		fchk(32'ha000_015c, 1'b0);
		fchk(32'ha000_0180, 1'b0);
		drain();
		chk(nwords < 8, 1'b1);
		wr(16'h0010, 32'h0000_3808);
		fchk(32'ha000_0200, 1'b0);
		gap_chk(32'ha000_0240, 7);
		drain();
		stop_test();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		stop_test();
	end
endmodule // code_fetch_cache_unit_tb
`default_nettype wire
